//--- core/ics_regs.vh
// Constants for the eight-channel serial bus switch control logic.
// Assumes inclusion by core design files only.
`ifndef ICS_REGS_VH
`define ICS_REGS_VH
`define ICS_ADDR_BASE 4'hE
`define ICS_SEL_RESET 8'h00
`define ICS_RW_READ 1'b1
`define ICS_RW_WRITE 1'b0
`define ICS_RST_LOW_MIN_NS 500
`define ICS_CLK_PERIOD_NS 5
`define ICS_RST_LOW_CYC ((`ICS_RST_LOW_MIN_NS + `ICS_CLK_PERIOD_NS - 1) / `ICS_CLK_PERIOD_NS)
`define ICS_SYNC_STAGES 3
`endif

//--- core/ics_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input and one reference clock.
`timescale 1ns/10ps
`default_nettype none
module ics_sync (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_pin,
  output reg o_level
);
  reg [2:0] stage;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      stage <= 3'h7;
      o_level <= 1'b1;
    end else begin
      stage <= {stage[1:0], i_pin};
      // First stage only feeds the second
      if (stage[1] == stage[2]) begin
        o_level <= stage[2];
      end
    end
  end
endmodule
`default_nettype wire

//--- core/ics_switch_ctrl.v
// Serial target control for an eight-channel bus switch.
// Assumes bus lines arrive asynchronous; open-drain data via output enable.
`timescale 1ns/10ps
`default_nettype none
`include "ics_regs.vh"
// Overview of operation
// - Address is 0x70 plus select pins
// - Write bit zero; acknowledge address, take byte
// - After read acknowledge, device shifts register out
// - Drive data per byte, release after not-acknowledge
// - Byte after write address is stored
// - Register readable; read returns stored value
// - Bit n enables downstream channel n
// - Any channel combination allowed
// - New selection applied only after stop
// - Acknowledge every byte, keep last one
// - Reset value all zeros, no channel
// - Reset pin held low clears everything
// - Power-on reset holds defaults while low
// - Power-on release starts from defaults
// - Further power-on reset needs supply cycle
module ics_switch_ctrl (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_por_n,
  input wire i_reset_pin_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_address_select_low,
  input wire i_address_select_mid,
  input wire i_address_select_high,
  output wire o_sda_out,
  output reg o_sda_oe,
  output reg [7:0] o_channel_enable,
  output reg [7:0] o_channel_select
);
  // One-hot so each state test is a single flop
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_AACK = 6'h04;
  localparam ST_WDAT = 6'h08;
  localparam ST_RDAT = 6'h10;
  localparam ST_RACK = 6'h20;
  localparam [31:0] RST_CYC_W = `ICS_RST_LOW_CYC;
  localparam [9:0] RST_CYC = RST_CYC_W[9:0];

  wire [5:0] pin_raw;
  wire [5:0] pin_s;
  wire [2:0] addr_s;
  wire scl_s;
  wire sda_s;
  wire rpin_s;
  genvar gi;
  reg scl_d;
  reg sda_d;
  reg [5:0] state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg rw;
  reg pending;
  reg [9:0] rst_cnt;
  wire pin_reset;
  wire any_reset;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire [6:0] own_addr;

  // Straps are pins too, so they share the same filter
  assign pin_raw = {i_address_select_high, i_address_select_mid, i_address_select_low,
    i_reset_pin_n, i_sda, i_scl};
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      ics_sync u_sync (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_pin(pin_raw[gi]),
        .o_level(pin_s[gi]));
    end
  endgenerate
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign rpin_s = pin_s[2];
  assign addr_s = pin_s[5:3];

  // Low-time filter keeps short glitches from wiping the selection
  always @(posedge i_ref_clk) begin
    if (!i_rst_n || rpin_s) begin
      rst_cnt <= 10'h000;
    end else if (rst_cnt != RST_CYC) begin
      rst_cnt <= rst_cnt + 10'h001;
    end
  end
  assign pin_reset = (rst_cnt == RST_CYC);
  // Power-on input held low by the supply monitor; cleared only by a supply cycle
  assign any_reset = !i_rst_n || !i_por_n || pin_reset;

  assign own_addr = {`ICS_ADDR_BASE, addr_s[2], addr_s[1], addr_s[0]};
  // Edges seen through the filter, a few cycles behind the pins
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;
  // Open drain: only ever pulls low
  assign o_sda_out = 1'b0;

  // Shared by the first bit and the rest of a read byte
  function drive_low;
    input [7:0] value;
    input [2:0] idx;
    begin
      drive_low = !value[idx];
    end
  endfunction

  // Every reset source clears the same set of flops
  always @(posedge i_ref_clk) begin
    if (any_reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      pending <= 1'b0;
      o_sda_oe <= 1'b0;
      o_channel_select <= `ICS_SEL_RESET;
      o_channel_enable <= `ICS_SEL_RESET;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
        // Lines are high at stop, so connecting now makes no false edges
        if (pending) begin
          o_channel_enable <= o_channel_select;
          pending <= 1'b0;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == own_addr) begin
                rw <= shreg[0];
                o_sda_oe <= 1'b1;
                state <= ST_AACK;
              end else begin
                // Foreign address: stay off the bus until the next start
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw == `ICS_RW_READ) begin
                // Reload so every byte returns the stored value
                shreg <= o_channel_select;
                o_sda_oe <= drive_low(o_channel_select, 3'h7);
                bitcnt <= 4'h1;
                state <= ST_RDAT;
              end else begin
                o_sda_oe <= 1'b0;
                bitcnt <= 4'h0;
                state <= ST_WDAT;
              end
            end
          end
          ST_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              // Each byte overwrites; only the last survives to the stop
              o_channel_select <= shreg;
              pending <= 1'b1;
              o_sda_oe <= 1'b1;
              state <= ST_AACK;
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                o_sda_oe <= 1'b0;
                state <= ST_RACK;
              end else begin
                o_sda_oe <= drive_low(shreg, 3'h7 - bitcnt[2:0]);
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              // Not-acknowledge: stay off the line until the next start
              state <= sda_s ? ST_IDLE : ST_AACK;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/ics_checker.sv
// Port checker for the switch control block.
// Assumes bind to the control top.
`timescale 1ns/10ps
`default_nettype none
module ics_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic i_reset_pin_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [7:0] o_channel_enable,
  input wire logic [7:0] o_channel_select
);
  logic [7:0] pin_low = 8'h00;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Saturates so a long hold never wraps
  always @(posedge i_ref_clk) begin
    pin_low <= i_reset_pin_n ? 8'h00 : pin_low + {7'h00, pin_low != 8'hFF};
  end
  property p_por;
    !i_por_n |=> o_channel_select == 8'h00 && o_channel_enable == 8'h00;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset left state");
  property p_pin;
    pin_low > 8'h6C |-> o_channel_enable == 8'h00 && !o_sda_oe;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin left state");
  property p_odrn;
    o_sda_out == 1'b0;
  endproperty
  a_odrn: assert property (p_odrn) else $error("data driven high");
  property p_ack;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack: assert property (p_ack) else $error("data pulled with clock high");
  property p_hold;
    $rose(o_sda_oe) |=> o_sda_oe [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("data bit too short");
  property p_rel;
    $fell(o_sda_oe) |-> !i_scl;
  endproperty
  a_rel: assert property (p_rel) else $error("release with clock high");
  property p_stop;
    $changed(o_channel_enable) && o_channel_enable != 8'h00 |-> i_scl && i_sda;
  endproperty
  a_stop: assert property (p_stop) else $error("applied outside stop");
  property p_map;
    $changed(o_channel_enable) |-> o_channel_enable == o_channel_select || !i_por_n ||
      !$past(i_por_n) || o_channel_enable == 8'h00;
  endproperty
  a_map: assert property (p_map) else $error("enable differs from select");
endmodule
bind ics_switch_ctrl ics_checker ics_checker_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_por_n(i_por_n), .i_reset_pin_n(i_reset_pin_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_channel_enable(o_channel_enable),
  .o_channel_select(o_channel_select));
`default_nettype wire

//--- bench/ics_host.sv
// Upstream bus controller model.
// Assumes a data pull-up; bit time 32 reference cycles.
`timescale 1ns/10ps
`default_nettype none
module ics_host (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_low = 1'b0
);
  task hb(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task start;
    hb(16);
    o_sda_low <= 1'b1;
    hb(16);
    o_scl <= 1'b0;
  endtask
  // Nine bits MSB first; a 1 releases data so reads work
  task xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      hb(4);
      o_sda_low <= !d[i];
      hb(12);
      o_scl <= 1'b1;
      hb(16);
      q[i] = i_sda;
      o_scl <= 1'b0;
    end
  endtask
  task stop;
    hb(4);
    o_sda_low <= 1'b1;
    hb(12);
    o_scl <= 1'b1;
    hb(16);
    o_sda_low <= 1'b0;
    hb(16);
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Bench for the switch control via the host model.
// Assumes straps set to address 0x75.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b1;
  logic pin_n = 1'b1;
  logic [2:0] strap = 3'h5;
  logic scl, sda_low, oe, sda_out;
  logic [7:0] en, sel;
  logic [8:0] q;
  // Pull-up wins unless a side pulls; the block drives its output only when enabled
  wire sda = !sda_low && (oe ? sda_out : 1'b1);
  int n_fail = 0;
  int num_checks = 0;
  always #2.5 clk = !clk;
  ics_host ics_host_i (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  ics_switch_ctrl ics_switch_ctrl_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_reset_pin_n(pin_n), .i_scl(scl), .i_sda(sda), .i_address_select_low(strap[0]),
    .i_address_select_mid(strap[1]), .i_address_select_high(strap[2]), .o_sda_out(sda_out),
    .o_sda_oe(oe), .o_channel_enable(en), .o_channel_select(sel));
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] b);
    ics_host_i.xfer({b, 1'b1}, q);
    chk("ack", {7'h00, q[0]}, 8'h00);
  endtask
  task wsel(input logic [7:0] a, input logic [7:0] b);
    ics_host_i.start;
    wr(a);
    wr(b);
    ics_host_i.stop;
  endtask
  task t_default;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("default", en | sel, 8'h00);
  endtask
  task t_write;
    ics_host_i.start;
    wr(8'hEA);
    wr(8'h5A);
    chk("held", en, 8'h00);
    wr(8'hC3);
    chk("select", sel, 8'hC3);
    ics_host_i.stop;
    chk("enable", en, 8'hC3);
  endtask
  task t_read;
    ics_host_i.start;
    wr(8'hEB);
    ics_host_i.xfer(9'h1FE, q);
    chk("read", q[8:1], 8'hC3);
    ics_host_i.xfer(9'h1FF, q);
    chk("read2", q[8:1], 8'hC3);
    ics_host_i.stop;
    chk("release", {7'h00, oe}, 8'h00);
  endtask
  task t_foreign;
    ics_host_i.start;
    ics_host_i.xfer(9'h1C1, q);
    chk("nack", {7'h00, q[0]}, 8'h01);
    ics_host_i.xfer(9'h001, q);
    ics_host_i.stop;
    chk("kept", en, 8'hC3);
  endtask
  task t_strap;
    strap <= 3'h0;
    wsel(8'hE0, 8'h10);
    chk("strap", en, 8'h10);
    ics_host_i.start;
    ics_host_i.xfer(9'h1D5, q);
    chk("old", {7'h00, q[0]}, 8'h01);
    ics_host_i.stop;
    strap <= 3'h5;
  endtask
  task t_reset;
    pin_n <= 1'b0;
    repeat (40) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("short", en, 8'h10);
    pin_n <= 1'b0;
    repeat (120) @(posedge clk);
    chk("pin", en | sel, 8'h00);
    pin_n <= 1'b1;
    wsel(8'hEA, 8'h80);
    chk("one", en, 8'h80);
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("por", en | sel, 8'h00);
    por_n <= 1'b1;
    wsel(8'hEA, 8'h24);
    chk("after", en, 8'h24);
  endtask
  task final_report;
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    t_default;
    t_write;
    t_read;
    t_foreign;
    t_strap;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
